// ---- src/srd_pkg.sv ----
package srd_pkg;

  // ***********************************************************
  // Frame layout
  // ***********************************************************
  localparam int unsigned FRAME_W     = 16;
  localparam int unsigned WORD_W      = 12;
  localparam logic [1:0]  SEL_WORD0   = 2'h2;
  localparam logic [1:0]  SEL_WORD1   = 2'h3;

  // ***********************************************************
  // Scratch word zero layout
  // ***********************************************************
  localparam int unsigned IDENT_FLAG_POS = 11;
  localparam int unsigned VERSION_LSB    = 7;
  localparam int unsigned VERSION_W      = 4;
  localparam int unsigned PART_W         = 7;
  // Arbitrary neutral identity values
  localparam logic [3:0]  VERSION_DEF    = 4'h1;
  localparam logic [6:0]  PART_DEF       = 7'h2A;
  localparam logic [11:0] WORD1_RST      = 12'h000;

  // ***********************************************************
  // Status reset values
  // ***********************************************************
  localparam logic [3:0] CAUSE_POWER_ON   = 4'h0;
  localparam logic [3:0] CAUSE_BANNED_SU  = 4'hC;
  localparam logic [3:0] CAUSE_RS_A       = 4'h0;
  localparam logic [3:0] CAUSE_RS_B       = 4'h2;
  localparam logic [3:0] CAUSE_RS_C       = 4'hC;
  localparam logic [3:0] CAUSE_RS_D       = 4'hE;
  localparam logic [1:0] LINE_FAIL_PO     = 2'h0;
  localparam logic       SEC_SUPPLY_PO    = 1'b1;
  localparam logic       MAIN_SUPPLY_PO   = 1'b0;
  localparam int unsigned IRQ_EN_W        = 8;

  // Serial frame as decoded by the select and write logic
  typedef struct packed {
    logic [1:0]        register_select_field;
    logic              readback_choice_bit;
    logic              no_write_flag;
    logic [WORD_W-1:0] data;
  } srd_frame_t;

  // System status fields
  typedef struct packed {
    logic [3:0] reset_cause_code;
    logic       line_wake_flag;
    logic       edge_wake_flag;
    logic       wake_pin_level;
    logic       thermal_warning_flag;
    logic       debug_mode_flag;
    logic       enable_pin_status;
    logic       first_power_flag;
  } srd_status_t;

  // System diagnosis fields
  typedef struct packed {
    logic [1:0] line_failure_code;
    logic       secondary_supply_ok;
    logic       main_supply_ok;
  } srd_diag_t;

endpackage

// ---- src/srd_word.sv ----
`timescale 1ns/1ps
// One scratch word with power-on load and host write
module srd_word
#(
  parameter int unsigned W        = 12,
  parameter logic        HAS_FLAG = 1'b0,
  parameter int unsigned FLAG_POS = 11
)
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         load_init,
  input  wire logic [W-1:0] init_value,
  input  wire logic [W-1:0] power_value,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] word_r
);
  logic [W-1:0] word_nxt;

  // Power-on load wins over a write in the same cycle
  always_comb
  begin
    word_nxt = word_r;
    if (load_init)
    begin
      word_nxt = init_value;
    end
    else if (wr_en)
    begin
      word_nxt = wr_data;
      if (HAS_FLAG)
      begin
        word_nxt[FLAG_POS] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      word_r <= '0;
    end
    else
    begin
      word_r <= word_nxt;
    end
  end

  // Not used; the word reads zero until the first clock after reset release
  logic unused_power;
  assign unused_power = |power_value;
endmodule

// ---- src/srd_regs.sv ----
`timescale 1ns/1ps
// ***********************************************************
// Scratch words and reset defaults
// ***********************************************************
// Notes on behaviour
// [RULE1] Two 12-bit scratch words keep host data for later read-back.
// [RULE2] Power-up loads word zero with identity, clears overwrite flag.
// [RULE3] Any write to word zero sets the overwrite flag regardless of data.
// [RULE4] Select 10 is word zero; choice bit picks its read-back or config.
// [RULE5] Select 11 is word one; choice bit picks its read-back or physical.
// [RULE6] No-write flag high only reads; low also writes data into the word.
// [RULE7] Word zero bit 11 is overwrite flag, bits 10 to 0 user content.
// [RULE8] Cause 0000 at power-on, never 1100 after start-up, four at restart.
// [RULE9] Line wake flag clears at power-on, set on line wake start-up.
// [RULE10] Edge wake flag clears at power-on, set on pin edge start-up.
// [RULE11] Entering power-on, start-up or restart forces defined field values.
// [RULE12] Identity code holds version in bits 10..7, part in 6..0.
// [RULE13] First power flag set only at power-on; enable status low on all.
// [RULE14] Enables clear at power-on; diagnosis takes fixed power-on values.
module srd_regs
  import srd_pkg::*;
#(
  parameter logic [VERSION_W-1:0] VERSION  = VERSION_DEF,
  parameter logic [PART_W-1:0]    PART     = PART_DEF,
  parameter int unsigned          IRQ_W    = IRQ_EN_W
)
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  frame_valid,
  input  wire srd_pkg::srd_frame_t   frame,
  input  wire logic [11:0]           sys_config_readback,
  input  wire logic [11:0]           phy_ctrl_readback,
  input  wire logic                  enter_power_on,
  input  wire logic                  enter_start_up,
  input  wire logic                  enter_restart,
  input  wire logic [3:0]            cause_in,
  input  wire logic                  wake_by_line,
  input  wire logic                  wake_by_edge,
  input  wire logic                  wake_pin_in,
  input  wire logic                  thermal_in,
  input  wire logic                  debug_mode_in,
  input  wire logic                  enable_pin_in,
  input  wire srd_pkg::srd_diag_t    diag_in,
  input  wire logic                  irq_en_wr,
  input  wire logic [IRQ_W-1:0]      irq_en_wdata,
  output logic                       reply_valid_r,
  output srd_pkg::srd_frame_t        reply_r,
  output logic [11:0]                word0_r,
  output logic [11:0]                word1_r,
  output srd_pkg::srd_status_t       status_r,
  output srd_pkg::srd_diag_t         diag_r,
  output logic [IRQ_W-1:0]           irq_en_r
);
  import srd_pkg::*;

  // ***********************************************************
  // Frame decode
  // ***********************************************************
  logic        hit0;
  logic        hit1;
  logic        wr0;
  logic        wr1;
  logic        power_up;
  logic [11:0] ident;
  logic        init_done_r;
  logic        init_done_nxt;

  // [RULE4] Select decode
  assign hit0 = frame_valid && (frame.register_select_field == SEL_WORD0);
  // [RULE5] Select decode
  assign hit1 = frame_valid && (frame.register_select_field == SEL_WORD1);
  // [RULE6] Write only when not read-only
  assign wr0  = hit0 && !frame.no_write_flag;
  assign wr1  = hit1 && !frame.no_write_flag;
  assign power_up = enter_power_on;

  // [RULE12] Identity layout
  assign ident = {1'b0, VERSION, PART};

  // ***********************************************************
  // Scratch words
  // ***********************************************************
  // [RULE2] Identity load, flag cleared
  // [RULE3] Flag forced on write
  // [RULE7] Flag at top bit
  srd_word #(
    .W        (WORD_W),
    .HAS_FLAG (1'b1),
    .FLAG_POS (IDENT_FLAG_POS)
  ) u_word0 (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .load_init   (power_up || !init_done_r),
    .init_value  (ident),
    .power_value (ident),
    .wr_en       (wr0),
    .wr_data     (frame.data),
    .word_r      (word0_r)
  );

  // [RULE1] Plain scratch word
  srd_word #(
    .W        (WORD_W),
    .HAS_FLAG (1'b0),
    .FLAG_POS (IDENT_FLAG_POS)
  ) u_word1 (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .load_init   (power_up || !init_done_r),
    .init_value  (WORD1_RST),
    .power_value (WORD1_RST),
    .wr_en       (wr1),
    .wr_data     (frame.data),
    .word_r      (word1_r)
  );

  // ***********************************************************
  // Reply path
  // ***********************************************************
  logic                reply_valid_nxt;
  srd_frame_t          reply_nxt;

  // Reply carries the old contents, so a write is seen on the next frame
  always_comb
  begin
    reply_valid_nxt = hit0 || hit1;
    reply_nxt       = reply_r;
    init_done_nxt   = 1'b1;
    if (hit0 || hit1)
    begin
      reply_nxt      = frame;
      // [RULE4] Word zero read choice
      if (hit0)
      begin
        reply_nxt.data = frame.readback_choice_bit ? word0_r
                                                   : sys_config_readback;
      end
      // [RULE5] Word one read choice
      else
      begin
        reply_nxt.data = frame.readback_choice_bit ? word1_r
                                                   : phy_ctrl_readback;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reply_valid_r <= 1'b0;
      reply_r       <= '0;
      init_done_r   <= 1'b0;
    end
    else
    begin
      reply_valid_r <= reply_valid_nxt;
      reply_r       <= reply_nxt;
      init_done_r   <= init_done_nxt;
    end
  end

  // ***********************************************************
  // Status, diagnosis and interrupt enables
  // ***********************************************************
  srd_status_t    status_nxt;
  srd_diag_t      diag_nxt;
  logic [IRQ_W-1:0] irq_en_nxt;
  logic           live_r;
  logic           live_nxt;
  logic           po;

  // Asynchronous reset counts as a power-on entry on the first edge
  assign po = power_up || !init_done_r;

  // Forced values on mode entry, live tracking otherwise; thermal and diagnosis only once live_r is set
  always_comb
  begin
    status_nxt = status_r;
    diag_nxt   = diag_r;
    irq_en_nxt = irq_en_r;
    live_nxt   = live_r;
    status_nxt.wake_pin_level  = wake_pin_in;
    status_nxt.debug_mode_flag = debug_mode_in;
    status_nxt.enable_pin_status = enable_pin_in;
    if (live_r)
    begin
      status_nxt.thermal_warning_flag = thermal_in;
      diag_nxt = diag_in;
    end
    if (irq_en_wr)
    begin
      irq_en_nxt = irq_en_wdata;
    end
    // [RULE11] Forced entry values
    if (po)
    begin
      live_nxt = 1'b0;
      // [RULE8] Power-on cause
      status_nxt.reset_cause_code     = CAUSE_POWER_ON;
      // [RULE9] Line wake cleared
      status_nxt.line_wake_flag       = 1'b0;
      // [RULE10] Edge wake cleared
      status_nxt.edge_wake_flag       = 1'b0;
      status_nxt.thermal_warning_flag = 1'b0;
      // [RULE13] First power set, enable low
      status_nxt.enable_pin_status    = 1'b0;
      status_nxt.first_power_flag     = 1'b1;
      // [RULE14] Enables cleared, fixed diagnosis
      irq_en_nxt = '0;
      diag_nxt.line_failure_code   = LINE_FAIL_PO;
      diag_nxt.secondary_supply_ok = SEC_SUPPLY_PO;
      diag_nxt.main_supply_ok      = MAIN_SUPPLY_PO;
    end
    else if (enter_start_up)
    begin
      live_nxt = 1'b1;
      // [RULE8] Banned code keeps the old cause
      if (cause_in != CAUSE_BANNED_SU)
      begin
        status_nxt.reset_cause_code = cause_in;
      end
      // A banned cause left by a restart must not survive start-up
      else if (status_r.reset_cause_code == CAUSE_BANNED_SU)
      begin
        status_nxt.reset_cause_code = CAUSE_POWER_ON;
      end
      // [RULE9] Sticky line wake
      if (wake_by_line)
      begin
        status_nxt.line_wake_flag = 1'b1;
      end
      // [RULE10] Sticky edge wake
      if (wake_by_edge)
      begin
        status_nxt.edge_wake_flag = 1'b1;
      end
      // [RULE13] Enable low
      status_nxt.enable_pin_status = 1'b0;
    end
    else if (enter_restart)
    begin
      live_nxt = 1'b1;
      // [RULE8] Only four legal restart codes; others read as 0000
      if (cause_in == CAUSE_RS_B || cause_in == CAUSE_RS_C ||
          cause_in == CAUSE_RS_D)
      begin
        status_nxt.reset_cause_code = cause_in;
      end
      else
      begin
        status_nxt.reset_cause_code = CAUSE_RS_A;
      end
      // [RULE13] Enable low
      status_nxt.enable_pin_status = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_r <= '{reset_cause_code: CAUSE_POWER_ON, first_power_flag: 1'b1,
                    default: 1'b0};
      diag_r   <= '{line_failure_code: LINE_FAIL_PO,
                    secondary_supply_ok: SEC_SUPPLY_PO,
                    main_supply_ok: MAIN_SUPPLY_PO};
      irq_en_r <= '0;
      live_r   <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      diag_r   <= diag_nxt;
      irq_en_r <= irq_en_nxt;
      live_r   <= live_nxt;
    end
  end
endmodule

// ---- dv/srd_host.sv ----
`timescale 1ns/1ps
// ****
// Host frame master
// ****
module srd_host
  import srd_pkg::*;
(
  input  wire logic                mclk,
  output srd_pkg::srd_frame_t      frame,
  output logic                     frame_valid,
  input  wire logic                reply_valid_r,
  input  wire srd_pkg::srd_frame_t reply_r
);
  // Idle bus at time zero
  initial
  begin
    frame_valid = 1'h0;
    frame = '0;
  end

  // One frame; the reply is read half a cycle after the taking edge
  task automatic xfer(input srd_frame_t f, output logic ok,
                      output srd_frame_t rep);
    @(negedge mclk);
    frame_valid <= 1'h1;
    frame <= f;
    @(negedge mclk);
    ok = reply_valid_r;
    rep = reply_r;
    frame_valid <= 1'h0;
    // Released lines must not look like the last frame
    frame <= ~f;
  endtask
endmodule

// ---- dv/srd_regs_assertions.sv ----
`timescale 1ns/1ps
// ****
// Port checks
// ****
module srd_chk
  import srd_pkg::*;
#(
  parameter int unsigned IRQ_W = 8
)
(
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic                 frame_valid,
  input wire srd_pkg::srd_frame_t  frame,
  input wire logic                 enter_power_on,
  input wire logic                 enter_start_up,
  input wire logic                 enter_restart,
  input wire logic                 wake_by_line,
  input wire logic                 reply_valid_r,
  input wire srd_pkg::srd_frame_t  reply_r,
  input wire logic [11:0]          word0_r,
  input wire logic [11:0]          word1_r,
  input wire srd_pkg::srd_status_t status_r,
  input wire logic [IRQ_W-1:0]     irq_en_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Decoded frame kinds
  wire logic sel0 = frame.register_select_field == SEL_WORD0;
  wire logic sel1 = frame.register_select_field == SEL_WORD1;
  wire logic w0 = frame_valid && sel0 && !frame.no_write_flag
                  && !enter_power_on;
  wire logic su = enter_start_up && !enter_power_on;

  reply_take_a: assert property (frame_valid && (sel0 || sel1)
    |=> reply_valid_r) else $error("no reply to a taken frame");
  flag_force_a: assert property (w0 |=> word0_r[11])
    else $error("overwrite flag not set");
  user_bits_a: assert property (w0
    |=> word0_r[10:0] == $past(frame.data[10:0]))
    else $error("word zero user bits wrong");
  read_only_a: assert property (frame_valid && frame.no_write_flag
    |=> $stable(word0_r) && $stable(word1_r))
    else $error("read-only frame changed a word");
  rb_one_a: assert property (frame_valid && sel1
    && frame.readback_choice_bit |=> reply_r.data == $past(word1_r))
    else $error("word one read-back wrong");
  ens_low_a: assert property (enter_power_on || su || enter_restart
    |=> !status_r.enable_pin_status) else $error("enable status high");
  po_vals_a: assert property (enter_power_on
    |=> status_r.reset_cause_code == CAUSE_POWER_ON
    && !status_r.line_wake_flag && irq_en_r == '0)
    else $error("power-on values wrong");
  su_cause_a: assert property (su
    |=> status_r.reset_cause_code != CAUSE_BANNED_SU)
    else $error("banned start-up cause");
  line_wake_a: assert property (su && wake_by_line
    |=> status_r.line_wake_flag) else $error("line wake flag clear");

  // Main scenarios reached
  cover property (w0);
  cover property (su && wake_by_line);
  cover property (enter_restart);
endmodule

bind srd_regs srd_chk #(.IRQ_W(IRQ_W)) srd_chk_i (.mclk, .arst_n,
  .frame_valid, .frame, .enter_power_on, .enter_start_up, .enter_restart,
  .wake_by_line, .reply_valid_r, .reply_r, .word0_r, .word1_r, .status_r,
  .irq_en_r);

// ---- dv/srd_regs_tb.sv ----
`timescale 1ns/1ps
module srd_regs_tb;
  import srd_pkg::*;
  localparam logic [11:0] IDENT = {1'h0, VERSION_DEF, PART_DEF};
  logic        mclk, arst_n, po, su, rs, wl, we, iw, fv, rv, ok;
  logic        wp, th, dm;
  logic [3:0]  cause;
  logic [7:0]  iwd, ie;
  logic [11:0] w0, w1;
  logic [11:0] cfg = 12'h5A5;
  logic [11:0] phy = 12'h3C3;
  srd_frame_t  fr, rr, rep;
  srd_status_t st;
  srd_diag_t   dg;
  int          mismatches, n_tests;

  srd_host srd_host_i (.mclk, .frame(fr), .frame_valid(fv),
    .reply_valid_r(rv), .reply_r(rr));
  srd_regs srd_regs_i (.mclk, .arst_n, .frame_valid(fv), .frame(fr),
    .sys_config_readback(cfg), .phy_ctrl_readback(phy),
    .enter_power_on(po), .enter_start_up(su), .enter_restart(rs),
    .cause_in(cause), .wake_by_line(wl), .wake_by_edge(we),
    .wake_pin_in(wp), .thermal_in(th), .debug_mode_in(dm),
    .enable_pin_in(1'h1), .diag_in(4'hD), .irq_en_wr(iw),
    .irq_en_wdata(iwd), .reply_valid_r(rv), .reply_r(rr), .word0_r(w0),
    .word1_r(w1), .status_r(st), .diag_r(dg), .irq_en_r(ie));

  // ****
  // Shared tasks
  // ****
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Frame that must be answered with data d
  task fx(input srd_frame_t f, input logic [11:0] d);
    srd_host_i.xfer(f, ok, rep);
    chk({3'h0, ok, rep.data}, {4'h1, d});
  endtask

  // Mode entry pulse, then cause, wake flags and enable status
  task mode(input logic [2:0] m, input logic [3:0] c, input logic l,
            input logic e, input logic [3:0] xc, input logic xl,
            input logic xe);
    @(negedge mclk);
    {po, su, rs} <= m;
    cause <= c;
    wl <= l;
    we <= e;
    @(negedge mclk);
    {po, su, rs} <= 3'h0;
    chk({9'h0, st.reset_cause_code, st.line_wake_flag,
         st.edge_wake_flag, st.enable_pin_status}, {9'h0, xc, xl, xe, 1'h0});
  endtask

  // ****
  // Scenarios
  // ****
  task t_reset;
    chk(16'(w0), 16'(IDENT));
    chk(16'(w1), 16'h0000);
    chk({3'h0, st.first_power_flag, st.reset_cause_code, ie},
        16'h1000);
    chk(16'(dg), 16'(srd_diag_t'{LINE_FAIL_PO, SEC_SUPPLY_PO,
                                 MAIN_SUPPLY_PO}));
  endtask

  task t_word0;
    fx({SEL_WORD0, 1'h1, 1'h1, 12'h000}, IDENT);
    chk(16'(w0), 16'(IDENT));
    fx({SEL_WORD0, 1'h1, 1'h0, 12'h3BC}, IDENT);
    chk(16'(w0), 16'h0BBC);
    fx({SEL_WORD0, 1'h0, 1'h1, 12'h000}, cfg);
    fx({SEL_WORD0, 1'h1, 1'h1, 12'h000}, 12'hBBC);
  endtask

  task t_word1;
    fx({SEL_WORD1, 1'h1, 1'h0, 12'hC3A}, 12'h000);
    fx({SEL_WORD1, 1'h1, 1'h1, 12'h5C5}, 12'hC3A);
    fx({SEL_WORD1, 1'h0, 1'h1, 12'h000}, phy);
    chk(16'(w1), 16'h0C3A);
  endtask

  // Other selects: no reply, old reply stands, no write
  task t_ignore;
    for (int i = 0; i < 2; i++)
    begin
      srd_host_i.xfer({2'(i), 1'h1, 1'h0, 12'h111}, ok, rep);
      chk({3'h0, ok, rep.data}, {4'h0, phy});
    end
    chk({4'h0, w1}, 16'h0C3A);
  endtask

  task t_modes;
    @(negedge mclk);
    iw <= 1'h1;
    iwd <= 8'hA5;
    @(negedge mclk);
    iw <= 1'h0;
    mode(3'h2, 4'h3, 1'h1, 1'h0, 4'h3, 1'h1, 1'h0);
    mode(3'h2, 4'hC, 1'h0, 1'h1, 4'h3, 1'h1, 1'h1);
    chk({ie, dg, st.first_power_flag, 3'h0}, 16'hA5D8);
    mode(3'h1, 4'h5, 1'h0, 1'h0, 4'h0, 1'h1, 1'h1);
    mode(3'h1, 4'hE, 1'h0, 1'h0, 4'hE, 1'h1, 1'h1);
    chk({w1, 4'h0}, 16'hC3A0);
    mode(3'h4, 4'h7, 1'h1, 1'h1, 4'h0, 1'h0, 1'h0);
    chk({ie, dg, st.first_power_flag, 3'h0}, 16'h0028);
  endtask

  // Live fields: thermal held at zero until the next mode entry
  task t_live;
    @(negedge mclk);
    {wp, th, dm} <= 3'h7;
    @(negedge mclk);
    chk({w0, 4'h0}, {IDENT, 4'h0});
    chk({12'h0, st.wake_pin_level, st.thermal_warning_flag,
         st.debug_mode_flag, st.enable_pin_status}, 16'h000B);
    mode(3'h1, 4'h2, 1'h0, 1'h0, 4'h2, 1'h0, 1'h0);
    @(negedge mclk);
    chk({12'h0, st.wake_pin_level, st.thermal_warning_flag,
         st.debug_mode_flag, st.enable_pin_status}, 16'h000F);
    mode(3'h1, 4'hC, 1'h0, 1'h0, 4'hC, 1'h0, 1'h0);
    mode(3'h2, 4'hC, 1'h0, 1'h0, 4'h0, 1'h0, 1'h0);
  endtask

  task finish_test;
    $display("Counts: %0d mismatches, %0d tests", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // 100 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Main sequence
  initial
  begin
    arst_n = 1'h0;
    {po, su, rs, iw, wl, we} = 6'h00;
    {wp, th, dm} = 3'h0;
    cause = 4'h0;
    iwd = 8'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(negedge mclk);
    arst_n = 1'h1;
    repeat (2) @(negedge mclk);
    t_reset;
    t_word0;
    t_word1;
    t_ignore;
    t_modes;
    t_live;
    finish_test;
  end

  // Watchdog, far beyond the roughly fifty cycles the tests need
  initial
  begin
    #20000;
    mismatches++;
    finish_test;
  end
endmodule
